// >>> design/rpes_pkg.sv
// Package: constants and carrier types for the radio power enable sequencer
package rpes_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ        = 10_000_000;
    localparam int POR_MAX_MS         = 110;
    // Longest time rounds down: ms * Hz / 1000
    localparam int POR_CYCLES         = (POR_MAX_MS * (CLK_FREQ_HZ / 1000));
    localparam int POR_CNT_W          = 21;
    localparam int HOST_ACCESS_MIN_MS = 150;
    localparam int DISCHARGE_MIN_MS   = 10;
    localparam int DISCHARGE_CYCLES   = (DISCHARGE_MIN_MS * (CLK_FREQ_HZ / 1000));

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic RST_ENABLE = 1'b0;
    localparam logic RST_SECT_N = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPES_OFF     = 2'b00,
        RPES_POR     = 2'b01,
        RPES_RUN     = 2'b10
    } rpes_state_t;

    // Section enables travelling together
    typedef struct packed {
        logic wlan_power_enable;
        logic shortrange_power_enable;
    } rpes_enables_t;

    // Section reset outputs, active low
    typedef struct packed {
        logic wlan_rst_n;
        logic shortrange_rst_n;
    } rpes_resets_t;

endpackage : rpes_pkg

// >>> design/rpes_por_timer.sv
// Power-on reset hold timer: counts a fixed number of cycles after start
`timescale 1ns/1ps
module rpes_por_timer #(
    parameter int CYCLES = 1100000
) (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    // Control
    input  wire logic run_in,
    // Status
    output logic      done_out
);

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic [rpes_pkg::POR_CNT_W-1:0] count_reg;
    // Two short of the hold: the registered release outside then lands
    // within CYCLES cycles of the supplies coming good, never one late
    localparam logic [rpes_pkg::POR_CNT_W-1:0] LAST =
        rpes_pkg::POR_CNT_W'(CYCLES - 2);

    // Count while running, clear when dropped
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !run_in) begin
            count_reg <= '0;
            done_out  <= 1'b0;
        end else if (count_reg != LAST) begin
            count_reg <= count_reg + 1'b1;
        end else begin
            done_out  <= 1'b1;
        end
    end

endmodule : rpes_por_timer

// >>> design/rpes_sequencer.sv
// Top: power enable OR, section resets and power-on reset hold
//
// Function
// - Regulators on when either enable high
// - LAN section reset while its enable low or the hold not over
// - Regulators off when both enables low
// - Short-range reset while its enable low
// - Power-on reset releases within 110 ms
`timescale 1ns/1ps
module rpes_sequencer #(
    parameter int POR_CYCLES = rpes_pkg::POR_CYCLES
) (
    // Clock and reset
    input  wire logic                   clock_in,
    input  wire logic                   rst_n_in,
    // Host enables
    input  wire rpes_pkg::rpes_enables_t enables_in,
    // Supplies good, from the supply monitors
    input  wire logic                   core_supply_ok_in,
    input  wire logic                   io_supply_ok_in,
    // Power management unit outputs
    output logic                        regulator_enable_out,
    output logic                        por_done_out,
    output rpes_pkg::rpes_resets_t      resets_out,
    output rpes_pkg::rpes_state_t       state_out
);

    // ------------------------------------------------------------------
    // Combined enable and supply state
    // ------------------------------------------------------------------
    logic any_enable;
    logic supplies_ok;
    logic por_done;
    rpes_pkg::rpes_state_t state_reg;
    rpes_pkg::rpes_state_t state_next;

    // Either section keeps the regulators alive
    assign any_enable  = enables_in.wlan_power_enable
                       | enables_in.shortrange_power_enable;
    assign supplies_ok = core_supply_ok_in & io_supply_ok_in;

    // ------------------------------------------------------------------
    // Power-on reset timer
    // ------------------------------------------------------------------
    // Restarts whenever a supply dips, so the hold is measured from the
    // last moment both supplies came good
    rpes_por_timer #(
        .CYCLES   (POR_CYCLES)
    ) u_por (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .run_in   (supplies_ok),
        .done_out (por_done)
    );

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    // Next state from enables, supplies and timer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rpes_pkg::RPES_OFF: begin
                if (any_enable) begin
                    state_next = rpes_pkg::RPES_POR;
                end
            end
            rpes_pkg::RPES_POR: begin
                if (!any_enable) begin
                    state_next = rpes_pkg::RPES_OFF;
                end else if (por_done) begin
                    state_next = rpes_pkg::RPES_RUN;
                end
            end
            rpes_pkg::RPES_RUN: begin
                if (!any_enable) begin
                    state_next = rpes_pkg::RPES_OFF;
                end else if (!supplies_ok) begin
                    state_next = rpes_pkg::RPES_POR;
                end
            end
            default: begin
                state_next = rpes_pkg::RPES_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= rpes_pkg::RPES_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // Regulator enable is a plain registered OR of the two enables
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            regulator_enable_out <= rpes_pkg::RST_ENABLE;
        end else begin
            regulator_enable_out <= any_enable;
        end
    end

    // Power-on reset release flag
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            por_done_out <= 1'b0;
        end else begin
            por_done_out <= por_done & supplies_ok;
        end
    end

    // Section resets: each gated by its own enable and by the hold;
    // short-range stays held even when the LAN side runs the regulators
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            resets_out <= '{wlan_rst_n: rpes_pkg::RST_SECT_N,
                            shortrange_rst_n: rpes_pkg::RST_SECT_N};
        end else begin
            resets_out.wlan_rst_n       <= enables_in.wlan_power_enable
                                         & por_done & supplies_ok;
            resets_out.shortrange_rst_n <= enables_in.shortrange_power_enable
                                         & por_done & supplies_ok;
        end
    end

    // Visible state for observation
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_out <= rpes_pkg::RPES_OFF;
        end else begin
            state_out <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Cycles spent with supplies good but the device still held; a counter
    // because the full hold is far too long for a delay range
    localparam logic [rpes_pkg::POR_CNT_W-1:0] POR_LIMIT =
        rpes_pkg::POR_CNT_W'(POR_CYCLES);
    logic [rpes_pkg::POR_CNT_W-1:0] held_cnt_reg;

    // Saturates rather than wraps, so a stuck hold keeps failing
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !supplies_ok || por_done_out) begin
            held_cnt_reg <= '0;
        end else if (held_cnt_reg != {rpes_pkg::POR_CNT_W{1'b1}}) begin
            held_cnt_reg <= held_cnt_reg + 1'b1;
        end
    end

    sequence both_low_s;
        !enables_in.wlan_power_enable && !enables_in.shortrange_power_enable;
    endsequence

    // Both supplies good and the hold over: sections may run
    sequence hold_over_s;
        supplies_ok && por_done;
    endsequence

    regulator_or_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        any_enable |=> regulator_enable_out)
        else $error("regulator not enabled with an enable high");

    regulator_off_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        both_low_s |=> !regulator_enable_out)
        else $error("regulator on with both enables low");

    wlan_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !enables_in.wlan_power_enable |=> !resets_out.wlan_rst_n)
        else $error("lan section out of reset while its enable low");

    wlan_release_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (enables_in.wlan_power_enable && por_done && supplies_ok)
        |=> resets_out.wlan_rst_n)
        else $error("lan section not released");

    shortrange_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (enables_in.wlan_power_enable && !enables_in.shortrange_power_enable)
        |=> (regulator_enable_out && !resets_out.shortrange_rst_n))
        else $error("short-range section released while its enable low");

    shortrange_reset_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !enables_in.shortrange_power_enable |=> !resets_out.shortrange_rst_n)
        else $error("short-range section out of reset while its enable low");

    shortrange_go_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (enables_in.shortrange_power_enable ##0 hold_over_s)
        |=> resets_out.shortrange_rst_n)
        else $error("short-range section not released");

    por_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(supplies_ok) |=> !por_done_out [*8])
        else $error("power-on reset released too early");

    por_release_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (supplies_ok && por_done) |=> por_done_out)
        else $error("power-on reset not released after hold");

    por_bound_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (supplies_ok && !por_done_out) |-> (held_cnt_reg < POR_LIMIT))
        else $error("power-on reset held beyond its longest time");

    supply_drop_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !supplies_ok |=> (!por_done_out && !resets_out.wlan_rst_n
                          && !resets_out.shortrange_rst_n))
        else $error("reset not reasserted on a supply drop");

    run_entry_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ((state_reg == rpes_pkg::RPES_POR && any_enable) ##0 hold_over_s)
        |=> (state_out == rpes_pkg::RPES_RUN))
        else $error("state not running after the hold");

    state_off_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        both_low_s |=> (state_out == rpes_pkg::RPES_OFF))
        else $error("state not off with both enables low");

endmodule : rpes_sequencer

// >>> tb/rpes_host_model.sv
// Host model: drives the section enables and keeps the host waits
`timescale 1ns/1ps
module rpes_host_model #(
    parameter int DISCH_CYCLES  = 10,
    parameter int ACCESS_CYCLES = 30
) (
    // Clock and reset
    input  wire logic                    clock_in,
    input  wire logic                    rst_n_in,
    // Requests and supply status
    input  wire logic [1:0]              req_in,
    input  wire logic                    supplies_ok_in,
    // Towards the device
    output rpes_pkg::rpes_enables_t      enables_out,
    output logic                         bus_ok_out
);
    int off_cnt;
    int on_cnt;

    // Discharge wait on own clock; nothing to discharge after reset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) off_cnt <= DISCH_CYCLES;
        else if (enables_out != 2'b00) off_cnt <= 0;
        else if (off_cnt < DISCH_CYCLES) off_cnt <= off_cnt + 1;
    end

    // Early raise requests are held back until the discharge wait ends
    // Zero count means an enable was high at the last edge; no output loop
    assign enables_out = (off_cnt == 0 || off_cnt >= DISCH_CYCLES) ? req_in : 2'b00;

    // Bus access allowed only after the supplies settled long enough
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !supplies_ok_in) on_cnt <= 0;
        else if (on_cnt < ACCESS_CYCLES) on_cnt <= on_cnt + 1;
    end
    assign bus_ok_out = (on_cnt >= ACCESS_CYCLES);
endmodule : rpes_host_model

// >>> tb/test_radio_power_enable_sequencer.sv
// Testbench: host model drives the sequencer, expectations queued and compared
`timescale 1ns/1ps
module test_radio_power_enable_sequencer;
    localparam int POR_CYC = 20;
    localparam int DISCH   = 10;
    localparam int ACCESS  = 30;
    logic clock_in;
    logic rst_n_in;
    logic [1:0] req;
    logic core_ok;
    logic io_ok;
    logic reg_en;
    logic por_done;
    logic bus_ok;
    rpes_pkg::rpes_enables_t enables;
    rpes_pkg::rpes_resets_t  resets;
    rpes_pkg::rpes_state_t   state;
    logic [5:0] exp_q[$];
    logic [1:0] prev_req = 2'b10;
    logic [1:0] v;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 34;

    rpes_host_model #(.DISCH_CYCLES(DISCH), .ACCESS_CYCLES(ACCESS)) rpes_host_model_i (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req),
        .supplies_ok_in(core_ok & io_ok), .enables_out(enables), .bus_ok_out(bus_ok));
    rpes_sequencer #(.POR_CYCLES(POR_CYC)) rpes_sequencer_i (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .enables_in(enables),
        .core_supply_ok_in(core_ok), .io_supply_ok_in(io_ok),
        .regulator_enable_out(reg_en), .por_done_out(por_done),
        .resets_out(resets), .state_out(state));

    // 10 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    task automatic check(input logic [5:0] seen, input logic [5:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    // Sequence: note {regulator, por done, lan reset_n, short reset_n, state}
    task automatic apply(input logic [1:0] val);
        rpes_pkg::rpes_state_t st;
        req <= val;
        @(posedge clock_in);
        if (val == 2'b00) st = rpes_pkg::RPES_OFF;
        else if (prev_req == 2'b00) st = rpes_pkg::RPES_POR;
        else st = rpes_pkg::RPES_RUN;
        exp_q.push_back({|val, 1'b1, val, st});
        prev_req = val;
        if (val == 2'b00) repeat (DISCH + 1) @(posedge clock_in);
    endtask : apply

    // Watcher on the settled falling edge; bounded run
    always @(negedge clock_in) begin
        cycles++;
        if (bus_ok) check({5'h00, por_done}, 6'h01, "por_before_bus");
        if (exp_q.size() > 0) check({reg_en, por_done, resets, state}, exp_q.pop_front(), "outputs");
        if (cycles > 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        rst_n_in <= 1'b0;
        req      <= 2'b00;
        core_ok  <= 1'b0;
        io_ok    <= 1'b0;
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        exp_q.push_back(6'h00);
        @(posedge clock_in);
        core_ok <= 1'b1;
        io_ok <= 1'b1;
        req <= 2'b10;
        @(posedge clock_in);
        exp_q.push_back({4'h8, rpes_pkg::RPES_POR});
        repeat (POR_CYC / 2) @(posedge clock_in);
        exp_q.push_back({4'h8, rpes_pkg::RPES_POR});
        repeat (POR_CYC) @(posedge clock_in);
        exp_q.push_back({4'hE, rpes_pkg::RPES_RUN});
        // Every enable code, then random ones
        for (int i = 0; i < 4; i++) apply(i[1:0]);
        repeat (40) begin
            v = 2'($random(seed));
            apply(v);
        end
        apply(2'b11);
        // Each supply drop restarts the hold and reasserts section resets;
        // release is looked for at the last cycle that the hold may take
        for (int s = 0; s < 2; s++) begin
            if (s == 0) io_ok <= 1'b0;
            else core_ok <= 1'b0;
            repeat (4) @(posedge clock_in);
            exp_q.push_back({4'h8, rpes_pkg::RPES_POR});
            io_ok <= 1'b1;
            core_ok <= 1'b1;
            repeat (POR_CYC) @(posedge clock_in);
            exp_q.push_back({4'hF, rpes_pkg::RPES_RUN});
        end
        repeat (15) @(posedge clock_in);
        end_sim();
    end
endmodule : test_radio_power_enable_sequencer
